// >>> srsf_pkg.sv
// Package: register map, field positions, reset values and carrier types of the serial receive block.
package srsf_pkg;
   // Register indices on the plain register port.
   localparam logic [2:0] SRSF_ADDR_DATA = 3'h0;
   localparam logic [2:0] SRSF_ADDR_STATUS = 3'h1;
   localparam logic [2:0] SRSF_ADDR_CTRL_B = 3'h2;
   localparam logic [2:0] SRSF_ADDR_FRAME_C = 3'h3;
   localparam logic [2:0] SRSF_ADDR_BAUD_LOW = 3'h4;
   // Status register field positions.
   localparam int SRSF_ST_RX_DONE = 7;
   localparam int SRSF_ST_FRAMING = 4;
   localparam int SRSF_ST_OVERRUN = 3;
   localparam int SRSF_ST_PARITY = 2;
   // Control register B field positions.
   localparam int SRSF_CB_RX_IRQ_EN = 7;
   localparam int SRSF_CB_RX_EN = 4;
   localparam int SRSF_CB_TX_EN = 3;
   localparam int SRSF_CB_RX_BIT8 = 1;
   localparam int SRSF_CB_TX_BIT8 = 0;
   // Frame control register C field positions.
   localparam int SRSF_FC_REG_SEL = 7;
   localparam int SRSF_FC_SYNC_MODE = 6;
   localparam int SRSF_FC_PAR_HIGH = 5;
   localparam int SRSF_FC_PAR_LOW = 4;
   localparam int SRSF_FC_STOP_SEL = 3;
   localparam int SRSF_FC_SIZE1 = 2;
   localparam int SRSF_FC_SIZE0 = 1;
   // Reset values.
   localparam logic [7:0] SRSF_FRAME_C_RESET = 8'h86;
   localparam logic [7:0] SRSF_CTRL_B_RESET = 8'h00;
   localparam logic [3:0] SRSF_BAUD_HIGH_RESET = 4'h0;
   localparam logic [7:0] SRSF_BAUD_LOW_RESET = 8'h00;
   // Receive buffer depth and oversampling.
   localparam int SRSF_BUF_DEPTH = 2;
   localparam logic [3:0] SRSF_OVS_LAST = 4'hF;
   localparam logic [3:0] SRSF_OVS_MID = 4'h7;
   localparam logic [1:0] SRSF_PAR_EVEN = 2'h2;
   localparam logic [1:0] SRSF_PAR_ODD = 2'h3;

   // One receive buffer entry: data with its error flags.
   typedef struct packed {
      logic [8:0] data;
      logic framing;
      logic overrun;
      logic parity;
   } srsf_entry_t;

   // Register port request.
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } srsf_bus_t;

   typedef enum logic [4:0] {
      SRSF_IDLE = 5'h01,
      SRSF_START = 5'h02,
      SRSF_DATA = 5'h04,
      SRSF_PARITY = 5'h08,
      SRSF_STOP = 5'h10
   } srsf_state_t;
endpackage

// >>> srsf_rx_status.sv
// Module: receive status, error flags, parity check and frame control of the serial transceiver.
`timescale 1ns/10ps
// Behaviour
// - Done flag high while unread data buffered
// - Clearing receiver enable flushes the buffer
// - Interrupt requested while done flag and enable
// - Data read clears done when buffer empties
// - Error flags travel with frame in buffer
// - Status writes never change error flags
// - Error flags raise no interrupt
// - Framing flag reflects first stop bit
// - Only first stop bit is checked
// - Overrun on start with buffer and shifter full
// - Overrun cleared on successful buffer transfer
// - Parity flag zero while checking disabled
// - Parity checker compares computed and received bit
// - Parity flag set only if enabled mismatch
// - Ninth transmit bit sent in nine-bit frames
// - Frame control shares location with baud high
// - Select bit reads one, must write one
// - Mode select zero means asynchronous
// - Parity field encoding, transmitter appends parity
// - Stop count for transmitter only
module srsf_rx_status
   import srsf_pkg::*;
#(
   parameter int DEPTH = SRSF_BUF_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Register port.
   input wire srsf_bus_t bus,
   output logic [7:0] rdata,
   // Serial receive line.
   input wire logic rx_line,
   // Receive interrupt request and global enable.
   input wire logic global_irq_enable,
   output logic rx_done_irq,
   // Configuration seen by the transmitter.
   output logic tx_ninth_bit,
   output logic nine_bit_frames,
   output logic tx_parity_enable,
   output logic tx_parity_odd,
   output logic tx_two_stop_bits,
   output logic sync_mode,
   output logic [11:0] baud_divisor,
   output logic [2:0] frame_size
);
   // ========================================
   // Registers
   logic [7:0] serial_control_b;
   logic [7:0] frame_control_c;
   logic [3:0] baud_divisor_high;
   logic [7:0] baud_divisor_low;
   srsf_entry_t buf_mem [DEPTH];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] fill;
   srsf_state_t state;
   logic [3:0] ovs;
   logic [3:0] bit_idx;
   logic [8:0] shift;
   logic par_calc;
   logic par_err;
   logic shift_full;
   srsf_entry_t shift_entry;
   logic overrun_pending;
   logic [11:0] baud_cnt;

   // ========================================
   // Decoding
   wire receiver_enable = serial_control_b[SRSF_CB_RX_EN];
   wire rx_done_irq_enable = serial_control_b[SRSF_CB_RX_IRQ_EN];
   wire parity_mode_high = frame_control_c[SRSF_FC_PAR_HIGH];
   wire parity_mode_low = frame_control_c[SRSF_FC_PAR_LOW];
   wire wr_data = bus.wr && bus.addr == SRSF_ADDR_DATA;
   wire rd_data = bus.rd && bus.addr == SRSF_ADDR_DATA;
   wire wr_ctrl_b = bus.wr && bus.addr == SRSF_ADDR_CTRL_B;
   wire wr_shared = bus.wr && bus.addr == SRSF_ADDR_FRAME_C;
   wire wr_frame_c = wr_shared && bus.wdata[SRSF_FC_REG_SEL];
   wire wr_baud_high = wr_shared && !bus.wdata[SRSF_FC_REG_SEL];
   wire [3:0] bits_total = nine_bit_frames ? 4'h9 : {1'b0, frame_size} + 4'h5;
   wire rx_done_flag = fill != 2'h0;
   wire buf_full = fill == DEPTH[1:0];
   wire pop = rd_data && rx_done_flag;
   wire tick = baud_cnt == 12'h000;
   wire sample = tick && ovs == SRSF_OVS_MID;
   wire bit_end = tick && ovs == SRSF_OVS_LAST;
   wire start_seen = state == SRSF_IDLE && !rx_line && receiver_enable;
   wire push = shift_full && (!buf_full || pop);
   srsf_entry_t head;
   assign head = buf_mem[rd_ptr];

   assign rx_done_irq = rx_done_flag && rx_done_irq_enable && global_irq_enable;
   assign tx_ninth_bit = serial_control_b[SRSF_CB_TX_BIT8];
   assign nine_bit_frames = frame_size == 3'h7;
   assign frame_size = {serial_control_b[2], frame_control_c[SRSF_FC_SIZE1],
      frame_control_c[SRSF_FC_SIZE0]};
   assign tx_parity_enable = parity_mode_high;
   assign tx_parity_odd = parity_mode_low;
   assign tx_two_stop_bits = frame_control_c[SRSF_FC_STOP_SEL];
   assign sync_mode = frame_control_c[SRSF_FC_SYNC_MODE];
   assign baud_divisor = {baud_divisor_high, baud_divisor_low};

   // Returns one when the computed parity disagrees with the received bit.
   function automatic logic parity_bad(input logic ones, input logic odd, input logic got);
      parity_bad = (ones ^ odd) != got;
   endfunction

   // ========================================
   // Register read path
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (bus.addr)
         SRSF_ADDR_DATA: next_rdata = head.data[7:0];
         SRSF_ADDR_STATUS: begin
            next_rdata[SRSF_ST_RX_DONE] = rx_done_flag;
            next_rdata[SRSF_ST_FRAMING] = rx_done_flag && head.framing;
            next_rdata[SRSF_ST_OVERRUN] = rx_done_flag && head.overrun;
            next_rdata[SRSF_ST_PARITY] = rx_done_flag && head.parity;
         end
         SRSF_ADDR_CTRL_B: next_rdata = {serial_control_b[7:2], head.data[8],
            serial_control_b[0]};
         SRSF_ADDR_FRAME_C: next_rdata = frame_control_c | 8'h80;
         SRSF_ADDR_BAUD_LOW: next_rdata = baud_divisor_low;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus.rd ? next_rdata : 8'h00;
      end
   end

   // ========================================
   // Control registers; status writes leave error flags untouched.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         serial_control_b <= SRSF_CTRL_B_RESET;
         frame_control_c <= SRSF_FRAME_C_RESET;
         baud_divisor_high <= SRSF_BAUD_HIGH_RESET;
         baud_divisor_low <= SRSF_BAUD_LOW_RESET;
      end else begin
         if (wr_ctrl_b) begin
            serial_control_b <= bus.wdata;
         end
         if (wr_frame_c) begin
            frame_control_c <= bus.wdata;
         end
         if (wr_baud_high) begin
            baud_divisor_high <= bus.wdata[3:0];
         end
         if (bus.wr && bus.addr == SRSF_ADDR_BAUD_LOW) begin
            baud_divisor_low <= bus.wdata;
         end
      end
   end

   // ========================================
   // Oversampling tick and receive state machine.
   always_ff @(posedge ref_clk) begin
      if (rst || state == SRSF_IDLE) begin
         baud_cnt <= baud_divisor;
      end else begin
         baud_cnt <= tick ? baud_divisor : baud_cnt - 12'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !receiver_enable) begin
         state <= SRSF_IDLE;
         ovs <= 4'h0;
         bit_idx <= 4'h0;
         shift <= 9'h000;
         par_calc <= 1'b0;
         par_err <= 1'b0;
      end else begin
         if (tick) begin
            ovs <= ovs + 4'h1;
         end
         unique case (state)
            SRSF_IDLE: begin
               ovs <= 4'h0;
               if (start_seen) begin
                  state <= SRSF_START;
               end
            end
            SRSF_START: begin
               if (sample && rx_line) begin
                  state <= SRSF_IDLE;
               end else if (bit_end) begin
                  state <= SRSF_DATA;
                  bit_idx <= 4'h0;
                  par_calc <= 1'b0;
               end
            end
            SRSF_DATA: begin
               if (sample) begin
                  shift[bit_idx] <= rx_line;
                  par_calc <= par_calc ^ rx_line;
               end
               if (bit_end) begin
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx + 4'h1 == bits_total) begin
                     state <= parity_mode_high ? SRSF_PARITY : SRSF_STOP;
                  end
               end
            end
            SRSF_PARITY: begin
               if (sample) begin
                  par_err <= parity_bad(par_calc, parity_mode_low, rx_line);
               end
               if (bit_end) begin
                  state <= SRSF_STOP;
               end
            end
            SRSF_STOP: begin
               if (sample) begin
                  state <= SRSF_IDLE;
               end
            end
            default: state <= SRSF_IDLE;
         endcase
      end
   end

   // ========================================
   // Shift holding entry, overrun detection and receive buffer.
   wire frame_done = state == SRSF_STOP && sample && receiver_enable;
   always_ff @(posedge ref_clk) begin
      if (rst || !receiver_enable) begin
         shift_full <= 1'b0;
         shift_entry <= '0;
         overrun_pending <= 1'b0;
      end else begin
         if (start_seen && buf_full && shift_full && !pop) begin
            overrun_pending <= 1'b1;
         end else if (push) begin
            overrun_pending <= 1'b0;
         end
         if (frame_done && !(shift_full && !push)) begin
            shift_full <= 1'b1;
            shift_entry.data <= shift;
            shift_entry.framing <= !rx_line;
            shift_entry.parity <= parity_mode_high && par_err;
            shift_entry.overrun <= 1'b0;
         end else if (push) begin
            shift_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !receiver_enable) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         fill <= 2'h0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr] <= '{data: shift_entry.data, framing: shift_entry.framing,
               overrun: overrun_pending, parity: shift_entry.parity};
            wr_ptr <= !wr_ptr;
         end
         if (pop) begin
            rd_ptr <= !rd_ptr;
         end
         fill <= fill + {1'b0, push} - {1'b0, pop};
      end
   end

   // ========================================
   // Assertions
   a_done_tracks_fill: assert property (@(posedge ref_clk) disable iff (rst)
      rx_done_flag == (fill != 2'h0)) else $error("done flag disagrees with fill");
   a_disable_flush: assert property (@(posedge ref_clk) disable iff (rst)
      !receiver_enable |=> fill == 2'h0) else $error("buffer not flushed");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
      rx_done_irq == (rx_done_flag && rx_done_irq_enable && global_irq_enable))
      else $error("interrupt level wrong");
   a_read_pops: assert property (@(posedge ref_clk) disable iff (rst)
      rd_data && fill == 2'h1 && !push && receiver_enable |=> !rx_done_flag)
      else $error("read did not clear done");
   a_status_write_keep: assert property (@(posedge ref_clk) disable iff (rst)
      bus.wr && bus.addr == SRSF_ADDR_STATUS && !push && !pop |=> $stable(head))
      else $error("status write changed flags");
   a_no_err_irq: assert property (@(posedge ref_clk) disable iff (rst)
      !rx_done_irq_enable |-> !rx_done_irq) else $error("error flag raised irq");
   a_framing_stop: assert property (@(posedge ref_clk) disable iff (rst)
      frame_done && !shift_full |=> shift_entry.framing == $past(!rx_line))
      else $error("framing flag wrong");
   a_parity_off: assert property (@(posedge ref_clk) disable iff (rst)
      frame_done && !parity_mode_high && !shift_full |=> !shift_entry.parity)
      else $error("parity flag set while disabled");
   a_overrun_set: assert property (@(posedge ref_clk) disable iff (rst)
      start_seen && buf_full && shift_full && !pop |=> overrun_pending)
      else $error("overrun missed");
   a_frame_c_sel: assert property (@(posedge ref_clk) disable iff (rst)
      bus.rd && bus.addr == SRSF_ADDR_FRAME_C |=> rdata[SRSF_FC_REG_SEL])
      else $error("select bit read zero");
   a_push_clears_ovr: assert property (@(posedge ref_clk) disable iff (rst)
      push && receiver_enable |=> !overrun_pending)
      else $error("overrun not cleared on transfer");
   a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !bus.rd |=> rdata == 8'h00) else $error("read data not zero when idle");
   a_fill_bound: assert property (@(posedge ref_clk) disable iff (rst)
      fill <= DEPTH[1:0]) else $error("buffer fill above depth");
   a_frame_c_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_frame_c |=> frame_control_c == $past(bus.wdata))
      else $error("frame control write lost");
   a_baud_high_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_baud_high |=> baud_divisor_high == $past(bus.wdata[3:0]) && $stable(frame_control_c))
      else $error("baud high write reached frame control");
   a_stop_once: assert property (@(posedge ref_clk) disable iff (rst)
      state == SRSF_STOP && sample && receiver_enable |=> state == SRSF_IDLE)
      else $error("receiver waited for extra stop bit");
   a_false_start: assert property (@(posedge ref_clk) disable iff (rst)
      state == SRSF_START && sample && rx_line && receiver_enable |=> state == SRSF_IDLE)
      else $error("false start not dropped");
   c_parity_err: cover property (@(posedge ref_clk) push && shift_entry.parity);
   c_framing_err: cover property (@(posedge ref_clk) push && shift_entry.framing);
   c_frame_in: cover property (@(posedge ref_clk) push);
   c_overrun: cover property (@(posedge ref_clk) overrun_pending && push);
   c_buf_full: cover property (@(posedge ref_clk) buf_full ##1 pop);
endmodule

// >>> srsf_tx_model.sv
// Partner model: remote serial transmitter that drives the receive line.
`timescale 1ns/10ps
module srsf_tx_model #(
   parameter int BIT_CLKS = 16
) (
   // Clock.
   input wire logic ref_clk,
   // Serial line, idle high.
   output logic rx_line
);
   initial rx_line = 1'b1;
   // Sends start, eight data bits LSB first, parity when pm[1] is set, one stop bit, idle bit.
   task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bad_par,
                       input logic stop_val);
      logic par;
      logic [10:0] fr;
      int n;
      par = (^d) ^ pm[0] ^ bad_par;
      fr = pm[1] ? {stop_val, par, d, 1'b0} : {1'b1, stop_val, d, 1'b0};
      n = pm[1] ? 11 : 10;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rx_line <= fr[i];
         repeat (BIT_CLKS - 1) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      rx_line <= 1'b1;
      repeat (BIT_CLKS) @(posedge ref_clk);
   endtask
endmodule

// >>> srsf_rx_status_tb.sv
// Testbench: self-checking bench of the serial receive status block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module srsf_rx_status_tb;
   import srsf_pkg::*;
   logic ref_clk, rst, rx_line, global_irq_enable, rx_done_irq, tx_ninth_bit;
   logic nine_bit_frames, tx_parity_enable, tx_parity_odd, tx_two_stop_bits, sync_mode;
   logic [7:0] rdata;
   logic [11:0] baud_divisor;
   logic [2:0] frame_size;
   srsf_bus_t bus;
   int n_mismatch = 0;
   int compares = 0;
   srsf_rx_status u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
      .rx_line(rx_line), .global_irq_enable(global_irq_enable), .rx_done_irq(rx_done_irq),
      .tx_ninth_bit(tx_ninth_bit), .nine_bit_frames(nine_bit_frames),
      .tx_parity_enable(tx_parity_enable), .tx_parity_odd(tx_parity_odd),
      .tx_two_stop_bits(tx_two_stop_bits), .sync_mode(sync_mode),
      .baud_divisor(baud_divisor), .frame_size(frame_size));
   srsf_tx_model u_tx (.ref_clk(ref_clk), .rx_line(rx_line));
   // ==========================================================
   // Register port tasks.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= {a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      bus <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      #1;
      `CHK("rdata", e, rdata)
   endtask
   task automatic set_gie(input logic v);
      @(posedge ref_clk);
      global_irq_enable <= v;
      #1;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      rd(SRSF_ADDR_FRAME_C, 8'h86);
      rd(SRSF_ADDR_STATUS, 8'h00);
      rd(3'h5, 8'h00);
      `CHK("irq", 1'b0, rx_done_irq)
   endtask
   task automatic t_basic;
      wr(SRSF_ADDR_CTRL_B, 8'h90);
      set_gie(1'b1);
      u_tx.send(8'hA5, 2'b00, 1'b0, 1'b1);
      rd(SRSF_ADDR_STATUS, 8'h80);
      `CHK("irq", 1'b1, rx_done_irq)
      set_gie(1'b0);
      `CHK("irq", 1'b0, rx_done_irq)
      set_gie(1'b1);
      rd(SRSF_ADDR_DATA, 8'hA5);
      rd(SRSF_ADDR_STATUS, 8'h00);
      `CHK("irq", 1'b0, rx_done_irq)
   endtask
   task automatic t_framing;
      wr(SRSF_ADDR_CTRL_B, 8'h10);
      u_tx.send(8'h3C, 2'b00, 1'b0, 1'b0);
      `CHK("irq", 1'b0, rx_done_irq)
      wr(SRSF_ADDR_STATUS, 8'h00);
      rd(SRSF_ADDR_STATUS, 8'h90);
      wr(SRSF_ADDR_CTRL_B, 8'h90);
      `CHK("irq", 1'b1, rx_done_irq)
      rd(SRSF_ADDR_DATA, 8'h3C);
      u_tx.send(8'h3D, 2'b00, 1'b0, 1'b1);
      rd(SRSF_ADDR_STATUS, 8'h80);
      rd(SRSF_ADDR_DATA, 8'h3D);
   endtask
   task automatic t_parity;
      for (int m = 2; m < 4; m++) begin
         wr(SRSF_ADDR_FRAME_C, 8'hA6 | {3'h0, m[0], 4'h0});
         rd(SRSF_ADDR_FRAME_C, 8'hA6 | {3'h0, m[0], 4'h0});
         `CHK("parity odd", m[0], tx_parity_odd)
         `CHK("parity on", 1'b1, tx_parity_enable)
         u_tx.send(8'h81 + 8'(m), 2'(m), 1'b0, 1'b1);
         u_tx.send(8'h81 + 8'(m), 2'(m), 1'b1, 1'b1);
         rd(SRSF_ADDR_STATUS, 8'h80);
         rd(SRSF_ADDR_DATA, 8'h81 + 8'(m));
         rd(SRSF_ADDR_STATUS, 8'h84);
         rd(SRSF_ADDR_DATA, 8'h81 + 8'(m));
         rd(SRSF_ADDR_STATUS, 8'h00);
      end
      wr(SRSF_ADDR_FRAME_C, 8'h86);
   endtask
   task automatic t_overrun;
      for (int i = 1; i < 5; i++) u_tx.send(8'(i * 17), 2'b00, 1'b0, 1'b1);
      for (int i = 1; i < 4; i++) begin
         rd(SRSF_ADDR_STATUS, (i == 3) ? 8'h88 : 8'h80);
         rd(SRSF_ADDR_DATA, 8'(i * 17));
      end
      rd(SRSF_ADDR_STATUS, 8'h00);
      u_tx.send(8'h55, 2'b00, 1'b0, 1'b1);
      rd(SRSF_ADDR_STATUS, 8'h80);
      rd(SRSF_ADDR_DATA, 8'h55);
   endtask
   task automatic t_flush;
      u_tx.send(8'h66, 2'b00, 1'b0, 1'b1);
      wr(SRSF_ADDR_CTRL_B, 8'h80);
      rd(SRSF_ADDR_STATUS, 8'h00);
      `CHK("irq", 1'b0, rx_done_irq)
   endtask
   task automatic t_ctrl;
      wr(SRSF_ADDR_CTRL_B, 8'h95);
      `CHK("ninth bit", 1'b1, tx_ninth_bit)
      `CHK("nine bits", 1'b1, nine_bit_frames)
      `CHK("size", 3'h7, frame_size)
      wr(SRSF_ADDR_FRAME_C, 8'h05);
      `CHK("baud", 12'h500, baud_divisor)
      rd(SRSF_ADDR_FRAME_C, 8'h86);
      wr(SRSF_ADDR_FRAME_C, 8'hCE);
      `CHK("sync", 1'b1, sync_mode)
      `CHK("two stop", 1'b1, tx_two_stop_bits)
      wr(SRSF_ADDR_FRAME_C, 8'h86);
      `CHK("sync", 1'b0, sync_mode)
      `CHK("two stop", 1'b0, tx_two_stop_bits)
   endtask
   // ==========================================================
   // Verdict, clock, watchdog and main sequence.
   task automatic summarize;
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      bus = '0;
      global_irq_enable = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_basic();
      t_framing();
      t_parity();
      t_overrun();
      t_flush();
      t_ctrl();
      summarize();
   end
endmodule
